// file: logic/nfc_device.sv
/*
 * Feature store end: decodes commands, takes feature address and four
 * parameter bytes, keeps timing and drive features, answers reads.
 * Assumes link pins are asynchronous to clk and held several cycles.
 */
// What this block and the host do
// - One address byte picks the parameter set
// - Resets keep features unless defined otherwise
// - Addresses 01h, 10h, 80h mapped; others reserved
// - Feature commands only while die idle
// - Set mode lasts until next command
// - Host waits address-to-data delay first
// - Async input latches on write strobe rise
// - Sync input latches on DQS rise, repeated
// - Sync update needs no repeated byte
// - Busy for feature time after four bytes
// - Interface change busy for change time
// - Get mode, busy after address given
// - Host restores read mode after status
// - Host never uses enhanced status
// - Async output one byte per read toggle
// - Sync output one byte per DQS edge
// - Timing bits 3:0, interface bits 5:4
// - Reset in sync mode restores timing defaults
// - Reset in async mode keeps timing
// - Drive bits 1:0, nominal default 02h
`timescale 1ns/1ps
`default_nettype none
module nfc_device (
	input wire logic clk,
	input wire logic rst_b,
	nfc_link_if.dev link,
	output logic syncActive,
	output logic [3:0] timingMode,
	output logic [1:0] driveLevelA,
	output logic [1:0] driveLevelB
);
	import nfc_pkg::*;

	logic [13:0] pinRaw;
	logic [13:0] pinMeta_q;
	logic [13:0] pinSync_q;
	logic [13:0] pinPrev_q;
	nfc_dstate_e st_q, st_d;
	logic [7:0] addr_q, addr_d;
	logic [2:0] idx_q, idx_d;
	logic [7:0] p1_q, p1_d;
	logic [BUSY_W-1:0] busy_q, busy_d;
	logic ready_q, ready_d;
	logic stat_q, stat_d;
	logic [3:0] timing_q, timing_d;
	logic [1:0] iface_q, iface_d;
	logic [1:0] drvA_q, drvA_d;
	logic [1:0] drvB_q, drvB_d;
	logic [7:0] dqOut_q, dqOut_d;
	logic dqOe_q, dqOe_d;
	logic dqsOut_q, dqsOut_d;
	logic dqsOe_q, dqsOe_d;
	logic cleS, aleS, weS, reS, lclkS, dqsS;
	logic cleP, aleP, weP, reP, lclkP, dqsP;
	logic [7:0] dqS;
	logic ifSync;
	logic latchStb, cmdStb, addrStb, dataStb;
	logic outLive, outAdv, drvWant;
	logic [7:0] featP1;
	logic [7:0] statusByte;
	logic [7:0] outByte;

	assign pinRaw = {link.cle, link.ale, link.weN, link.reN, link.linkClk, link.dqs, link.dq};

	// Pins are asynchronous; the first stage never feeds logic, the second and third do
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Idle pin levels, so no false strobe edge follows reset
			pinMeta_q <= 14'h0c00;
			pinSync_q <= 14'h0c00;
			pinPrev_q <= 14'h0c00;
		end else begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
		end
	end

	assign {cleS, aleS, weS, reS, lclkS, dqsS, dqS} = pinSync_q;
	assign {cleP, aleP, weP, reP, lclkP, dqsP} = pinPrev_q[13:8];
	assign ifSync = (iface_q == IF_SYNC);

	// Async: write strobe rise; sync: link clock rise
	assign latchStb = ifSync ? (lclkS & ~lclkP) : (weS & ~weP);
	assign cmdStb = latchStb & cleS & ~aleS;
	assign addrStb = latchStb & aleS & ~cleS;
	assign dataStb = ifSync ? (dqsS & ~dqsP & cleS & aleS) : (weS & ~weP & ~cleS & ~aleS);
	assign outLive = (st_q == DS_GET_OUT) & ~stat_q & ready_q;
	// Needs latches high a cycle before, so the enabling edge is not counted
	assign outAdv = (lclkS ^ lclkP) & cleS & aleS & cleP & aleP;
	assign drvWant = cleS & aleS & (stat_q | (st_q == DS_GET_OUT));

	always_comb begin
		featP1 = 8'h00;
		case (addr_q)
			FA_TIMING: featP1 = {2'b00, iface_q, timing_q};
			FA_DRIVE_A: featP1 = {6'h00, drvA_q};
			FA_DRIVE_B: featP1 = {6'h00, drvB_q};
			default: featP1 = 8'h00;
		endcase
	end

	always_comb begin
		statusByte = 8'h00;
		statusByte[ST_WP_N] = 1'b1;
		statusByte[ST_RDY] = ready_q;
		statusByte[ST_ARDY] = ready_q;
		outByte = stat_q ? statusByte : ((idx_q == 3'h0) ? featP1 : 8'h00);
	end

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		idx_d = idx_q;
		p1_d = p1_q;
		busy_d = busy_q;
		stat_d = stat_q;
		timing_d = timing_q;
		iface_d = iface_q;
		drvA_d = drvA_q;
		drvB_d = drvB_q;
		dqOut_d = dqOut_q;
		dqOe_d = dqOe_q;
		dqsOut_d = dqsOut_q;
		dqsOe_d = dqsOe_q;
		if (busy_q != '0) begin
			busy_d = busy_q - 1'b1;
		end
		if (cmdStb) begin
			if (st_q == DS_SET_ADDR || st_q == DS_SET_DATA) begin
				st_d = DS_IDLE;
			end
			case (dqS)
				CMD_SET_FEAT: begin
					stat_d = 1'b0;
					if (ready_q) begin
						st_d = DS_SET_ADDR;
					end
				end
				CMD_GET_FEAT: begin
					stat_d = 1'b0;
					if (ready_q) begin
						st_d = DS_GET_ADDR;
					end
				end
				CMD_RESET: begin
					st_d = DS_IDLE;
					stat_d = 1'b0;
					busy_d = RST_CNT;
					// Drive levels untouched by either reset command; only rst_b reloads DRV_RESET
					if (ifSync) begin
						timing_d = TM_RESET;
						iface_d = IF_ASYNC;
					end
				end
				CMD_SYNC_RESET: begin
					if (ifSync) begin
						st_d = DS_IDLE;
						stat_d = 1'b0;
						busy_d = RST_CNT;
					end
				end
				CMD_READ_STATUS: stat_d = 1'b1;
				CMD_READ_MODE: stat_d = 1'b0;
				default: stat_d = stat_q;
			endcase
		end else if (addrStb) begin
			if (st_q == DS_SET_ADDR) begin
				addr_d = dqS;
				idx_d = 3'h0;
				st_d = DS_SET_DATA;
			end else if (st_q == DS_GET_ADDR) begin
				addr_d = dqS;
				idx_d = 3'h0;
				st_d = DS_GET_OUT;
				busy_d = FEAT_CNT;
			end
		end else if (dataStb && st_q == DS_SET_DATA && idx_q < PARAM_END) begin
			idx_d = idx_q + 3'h1;
			if (idx_q == 3'h0) begin
				p1_d = dqS;
			end
			// Acts on the fourth rise; the repeated copy is not awaited
			if (idx_q == PARAM_LAST) begin
				busy_d = FEAT_CNT;
				case (addr_q)
					FA_TIMING: begin
						timing_d = p1_q[TM_LSB +: 4];
						iface_d = p1_q[IF_LSB +: 2];
						if (p1_q[IF_LSB +: 2] != iface_q) begin
							busy_d = ITC_CNT;
						end
					end
					FA_DRIVE_A: drvA_d = p1_q[DRV_LSB +: 2];
					FA_DRIVE_B: drvB_d = p1_q[DRV_LSB +: 2];
					default: busy_d = FEAT_CNT;
				endcase
			end
		end
		if (ifSync) begin
			dqOe_d = drvWant;
			dqsOe_d = drvWant;
			if (!drvWant) begin
				dqsOut_d = 1'b0;
			end else if (outAdv) begin
				dqOut_d = outByte;
				dqsOut_d = ~dqsOut_q;
				if (outLive && idx_q < PARAM_END) begin
					idx_d = idx_q + 3'h1;
				end
			end
		end else begin
			dqOe_d = ~reS & (stat_q | (st_q == DS_GET_OUT));
			dqOut_d = outByte;
			dqsOe_d = 1'b0;
			dqsOut_d = 1'b0;
			if (reS && !reP && outLive && idx_q < PARAM_END) begin
				idx_d = idx_q + 3'h1;
			end
		end
		ready_d = (busy_d == '0);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= DS_IDLE;
			addr_q <= 8'h00;
			idx_q <= 3'h0;
			p1_q <= 8'h00;
			busy_q <= '0;
			ready_q <= 1'b1;
			stat_q <= 1'b0;
			timing_q <= TM_RESET;
			iface_q <= IF_ASYNC;
			drvA_q <= DRV_RESET;
			drvB_q <= DRV_RESET;
			dqOut_q <= 8'h00;
			dqOe_q <= 1'b0;
			dqsOut_q <= 1'b0;
			dqsOe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			idx_q <= idx_d;
			p1_q <= p1_d;
			busy_q <= busy_d;
			ready_q <= ready_d;
			stat_q <= stat_d;
			timing_q <= timing_d;
			iface_q <= iface_d;
			drvA_q <= drvA_d;
			drvB_q <= drvB_d;
			dqOut_q <= dqOut_d;
			dqOe_q <= dqOe_d;
			dqsOut_q <= dqsOut_d;
			dqsOe_q <= dqsOe_d;
		end
	end

	assign link.devDq = dqOut_q;
	assign link.devDqOe = dqOe_q;
	assign link.devDqs = dqsOut_q;
	assign link.devDqsOe = dqsOe_q;
	assign link.rdy = ready_q;
	assign syncActive = ifSync;
	assign timingMode = timing_q;
	assign driveLevelA = drvA_q;
	assign driveLevelB = drvB_q;
endmodule : nfc_device
`default_nettype wire

// file: pkg/nfc_pkg.sv
/*
 * Shared constants and types for the feature-store link: command codes,
 * feature addresses, field layout, reset values and busy timings.
 * Assumes both ends run from a 125 MHz clock.
 */
package nfc_pkg;
	localparam int CLK_NS = 8;

	localparam logic [7:0] CMD_SET_FEAT = 8'hef;
	localparam logic [7:0] CMD_GET_FEAT = 8'hee;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_SYNC_RESET = 8'hfc;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_MODE = 8'h00;

	localparam logic [7:0] FA_TIMING = 8'h01;
	localparam logic [7:0] FA_DRIVE_A = 8'h10;
	localparam logic [7:0] FA_DRIVE_B = 8'h80;

	localparam int TM_LSB = 0;
	localparam int IF_LSB = 4;
	localparam int DRV_LSB = 0;
	localparam logic [3:0] TM_RESET = 4'h0;
	localparam logic [1:0] IF_ASYNC = 2'h0;
	localparam logic [1:0] IF_SYNC = 2'h1;
	localparam logic [1:0] DRV_RESET = 2'h2;

	localparam int ST_WP_N = 7;
	localparam int ST_RDY = 6;
	localparam int ST_ARDY = 5;

	localparam logic [2:0] PARAM_LAST = 3'h3;
	localparam logic [2:0] PARAM_END = 3'h4;

	localparam int FEAT_BUSY_NS = 1000;
	localparam int ITC_NS = 1500;
	localparam int RST_NS = 5000;
	localparam int ADL_NS = 70;
	localparam int BUSY_W = 10;
	localparam logic [BUSY_W-1:0] FEAT_CNT = BUSY_W'(FEAT_BUSY_NS / CLK_NS);
	localparam logic [BUSY_W-1:0] ITC_CNT = BUSY_W'(ITC_NS / CLK_NS);
	localparam logic [BUSY_W-1:0] RST_CNT = BUSY_W'(RST_NS / CLK_NS);
	localparam logic [3:0] ADL_CNT = 4'((ADL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] HALF_LAST = 3'h7;

	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_SET_ADDR = 3'b001,
		DS_SET_DATA = 3'b010,
		DS_GET_ADDR = 3'b011,
		DS_GET_OUT = 3'b100
	} nfc_dstate_e;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_ARM = 3'b001,
		HS_CMD = 3'b010,
		HS_ADDR = 3'b011,
		HS_ADL = 3'b100,
		HS_WDATA = 3'b101,
		HS_WAIT = 3'b110,
		HS_RDATA = 3'b111
	} nfc_hstate_e;

	typedef enum logic [1:0] {
		OP_SET = 2'b00,
		OP_GET = 2'b01,
		OP_RESET = 2'b10,
		OP_SYNC_RESET = 2'b11
	} nfc_op_e;
endpackage : nfc_pkg

// file: pkg/nfc_link_if.sv
/*
 * Link between controller and feature store: latches, strobes, data bus.
 * Resolves the shared data and strobe wires from each side's enables.
 */
`timescale 1ns/1ps
`default_nettype none
interface nfc_link_if;
	logic cle;
	logic ale;
	logic weN;
	logic reN;
	logic linkClk;
	logic [7:0] hostDq;
	logic hostDqOe;
	logic hostDqs;
	logic hostDqsOe;
	logic [7:0] devDq;
	logic devDqOe;
	logic devDqs;
	logic devDqsOe;
	logic rdy;
	logic [7:0] dq;
	logic dqs;

	// Undriven bus reads low; the device wins a clash
	assign dq = devDqOe ? devDq : (hostDqOe ? hostDq : 8'h00);
	assign dqs = devDqsOe ? devDqs : (hostDqsOe ? hostDqs : 1'b0);

	modport dev (input cle, ale, weN, reN, linkClk, dq, dqs,
		output devDq, devDqOe, devDqs, devDqsOe, rdy);
	modport host (input dq, dqs, rdy,
		output cle, ale, weN, reN, linkClk, hostDq, hostDqOe, hostDqs, hostDqsOe);
endinterface : nfc_link_if
`default_nettype wire

// file: logic/nfc_host.sv
/*
 * Controller end: runs set, get and reset sequences on the link from
 * single requests; derives the link clock by dividing clk by sixteen.
 * Assumes one request at a time and the far end on the same link.
 */
`timescale 1ns/1ps
`default_nettype none
module nfc_host (
	input wire logic clk,
	input wire logic rst_b,
	nfc_link_if.host link,
	input wire logic reqValid,
	input wire nfc_pkg::nfc_op_e reqOp,
	input wire logic [7:0] reqAddr,
	input wire logic [7:0] reqParam,
	output logic reqReady,
	output logic rspValid,
	output logic [31:0] rspData,
	output logic linkSync
);
	import nfc_pkg::*;

	logic [9:0] inMeta_q, inSync_q, inPrev_q;
	nfc_hstate_e st_q, st_d, nxt;
	nfc_op_e op_q, op_d;
	logic [7:0] addr_q, addr_d, param_q, param_d;
	logic [2:0] div_q, div_d;
	logic ph_q, ph_d;
	logic [1:0] idx_q, idx_d;
	logic sub_q, sub_d;
	logic [3:0] cnt_q, cnt_d;
	logic cle_q, cle_d, ale_q, ale_d, weN_q, weN_d, reN_q, reN_d;
	logic [7:0] dq_q, dq_d;
	logic dqOe_q, dqOe_d, dqs_q, dqs_d, dqsOe_q, dqsOe_d;
	logic [7:0] byte_q [4];
	logic [7:0] byte_d [4];
	logic rsp_q, rsp_d, sync_q, sync_d;
	logic tick, lowTick, highTick, rdyS, dqsEdge, done;
	logic [7:0] dqS, cmdCode;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inMeta_q <= 10'h000;
			inSync_q <= 10'h000;
			inPrev_q <= 10'h000;
		end else begin
			inMeta_q <= {link.rdy, link.dqs, link.dq};
			inSync_q <= inMeta_q;
			inPrev_q <= inSync_q;
		end
	end

	assign {rdyS, dqS} = {inSync_q[9], inSync_q[7:0]};
	assign dqsEdge = inSync_q[8] ^ inPrev_q[8];
	assign tick = (div_q == HALF_LAST);
	assign lowTick = tick & ph_q;
	assign highTick = tick & ~ph_q;

	always_comb begin
		unique case (op_q)
			OP_SET: cmdCode = CMD_SET_FEAT;
			OP_GET: cmdCode = CMD_GET_FEAT;
			OP_RESET: cmdCode = CMD_RESET;
			OP_SYNC_RESET: cmdCode = CMD_SYNC_RESET;
		endcase
	end

	always_comb begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		param_d = param_q;
		div_d = tick ? 3'h0 : div_q + 3'h1;
		ph_d = tick ? ~ph_q : ph_q;
		idx_d = idx_q;
		sub_d = sub_q;
		cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
		{cle_d, ale_d, weN_d, reN_d} = {cle_q, ale_q, weN_q, reN_q};
		{dq_d, dqOe_d, dqs_d, dqsOe_d} = {dq_q, dqOe_q, dqs_q, dqsOe_q};
		byte_d = byte_q;
		rsp_d = 1'b0;
		sync_d = sync_q;
		nxt = st_q;
		done = 1'b0;
		if (st_q == HS_IDLE && reqValid && reqReady) begin
			op_d = reqOp;
			addr_d = reqAddr;
			param_d = reqParam;
			st_d = HS_ARM;
		end
		if (highTick) begin
			weN_d = 1'b1;
			reN_d = 1'b1;
			if (st_q == HS_RDATA && !sync_q) begin
				byte_d[idx_q] = dqS;
			end
			if (st_q == HS_WDATA && sync_q) begin
				dqs_d = ~sub_q;
			end
		end
		if (st_q == HS_RDATA && sync_q && dqsEdge) begin
			byte_d[idx_q] = dqS;
			idx_d = idx_q + 2'h1;
			done = (idx_q == 2'h3);
		end
		if (lowTick) begin
			unique case (st_q)
				// Keeps a request taken on this very tick
				HS_IDLE: nxt = st_d;
				HS_ARM: nxt = HS_CMD;
				HS_CMD: nxt = (op_q == OP_SET || op_q == OP_GET) ? HS_ADDR : HS_WAIT;
				HS_ADDR: begin
					nxt = (op_q == OP_SET) ? HS_ADL : HS_WAIT;
					cnt_d = ADL_CNT;
				end
				HS_ADL: begin
					if (cnt_q == 4'h0) begin
						nxt = HS_WDATA;
						idx_d = 2'h0;
						sub_d = 1'b0;
					end
				end
				HS_WDATA: begin
					if (sync_q && !sub_q) begin
						sub_d = 1'b1;
					end else if (idx_q == 2'h3) begin
						nxt = HS_WAIT;
					end else begin
						idx_d = idx_q + 2'h1;
						sub_d = 1'b0;
					end
				end
				// Watches the ready pin, never an enhanced status read
				HS_WAIT: begin
					if (rdyS) begin
						if (op_q == OP_GET) begin
							nxt = HS_RDATA;
							idx_d = 2'h0;
						end else begin
							done = 1'b1;
						end
					end
				end
				HS_RDATA: begin
					if (!sync_q) begin
						if (idx_q == 2'h3) begin
							done = 1'b1;
						end else begin
							idx_d = idx_q + 2'h1;
						end
					end
				end
			endcase
			if (!done) begin
				st_d = nxt;
				cle_d = (nxt == HS_CMD) | (sync_q & (nxt == HS_WDATA || nxt == HS_RDATA));
				ale_d = (nxt == HS_ADDR) | (sync_q & (nxt == HS_WDATA || nxt == HS_RDATA));
				weN_d = ~(~sync_q & (nxt == HS_CMD || nxt == HS_ADDR || nxt == HS_WDATA));
				reN_d = ~(~sync_q & (nxt == HS_RDATA));
				dqOe_d = (nxt == HS_CMD || nxt == HS_ADDR || nxt == HS_WDATA);
				dq_d = (nxt == HS_CMD) ? cmdCode : ((nxt == HS_ADDR) ? addr_q : 8'h00);
				if (nxt == HS_WDATA && idx_d == 2'h0) begin
					dq_d = param_q;
				end
				dqsOe_d = sync_q & (nxt == HS_WDATA);
				dqs_d = (nxt == HS_WDATA && sub_d) ? dqs_q : 1'b0;
			end
		end
		if (done) begin
			st_d = HS_IDLE;
			rsp_d = 1'b1;
			{cle_d, ale_d, weN_d, reN_d} = 4'h3;
			{dqOe_d, dqsOe_d, dqs_d} = 3'h0;
			if (op_q == OP_SET && addr_q == FA_TIMING) begin
				sync_d = (param_q[IF_LSB +: 2] == IF_SYNC);
			end
			if (op_q == OP_RESET) begin
				sync_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= HS_IDLE;
			op_q <= OP_SET;
			addr_q <= 8'h00;
			param_q <= 8'h00;
			div_q <= 3'h0;
			ph_q <= 1'b0;
			idx_q <= 2'h0;
			sub_q <= 1'b0;
			cnt_q <= 4'h0;
			{cle_q, ale_q, weN_q, reN_q} <= 4'h3;
			{dq_q, dqOe_q, dqs_q, dqsOe_q} <= 11'h000;
			byte_q <= '{default: 8'h00};
			rsp_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			addr_q <= addr_d;
			param_q <= param_d;
			div_q <= div_d;
			ph_q <= ph_d;
			idx_q <= idx_d;
			sub_q <= sub_d;
			cnt_q <= cnt_d;
			{cle_q, ale_q, weN_q, reN_q} <= {cle_d, ale_d, weN_d, reN_d};
			{dq_q, dqOe_q, dqs_q, dqsOe_q} <= {dq_d, dqOe_d, dqs_d, dqsOe_d};
			byte_q <= byte_d;
			rsp_q <= rsp_d;
			sync_q <= sync_d;
		end
	end

	assign reqReady = (st_q == HS_IDLE) & rdyS;
	assign rspValid = rsp_q;
	assign rspData = {byte_q[3], byte_q[2], byte_q[1], byte_q[0]};
	assign linkSync = sync_q;
	assign {link.cle, link.ale, link.weN, link.reN} = {cle_q, ale_q, weN_q, reN_q};
	assign link.linkClk = ph_q;
	assign {link.hostDq, link.hostDqOe} = {dq_q, dqOe_q};
	assign {link.hostDqs, link.hostDqsOe} = {dqs_q, dqsOe_q};
endmodule : nfc_host
`default_nettype wire

// file: verification/nfc_link_chk.sv
/*
 * Concurrent checks on the feature-store link: busy length, output
 * enables, strobe spacing and command discipline of the controller.
 * Assumes it sits beside the link interface and shares clk with both ends.
 */
`timescale 1ns/1ps
`default_nettype none
module nfc_link_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cle,
	input wire logic ale,
	input wire logic weN,
	input wire logic reN,
	input wire logic [7:0] hostDq,
	input wire logic hostDqOe,
	input wire logic hostDqs,
	input wire logic hostDqsOe,
	input wire logic devDqOe,
	input wire logic devDqs,
	input wire logic devDqsOe,
	input wire logic rdy
);
	import nfc_pkg::*;

	logic [BUSY_W-1:0] lowCnt_q;
	logic [7:0] dqRise_q;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Longest busy is 625, so the counter never wraps
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_q <= '0;
			dqRise_q <= 8'h00;
		end else begin
			lowCnt_q <= rdy ? '0 : lowCnt_q + 1'b1;
			if ($rose(hostDqs)) begin
				dqRise_q <= hostDq;
			end
		end
	end

	AST_BUSY_LEN: assert property ($rose(rdy) |->
		lowCnt_q == FEAT_CNT || lowCnt_q == ITC_CNT || lowCnt_q == RST_CNT)
		else $error("busy time of undefined length");
	AST_NO_OUT_BUSY: assert property (!rdy |-> !devDqOe)
		else $error("data driven while busy");
	AST_OE_CAUSE: assert property ($rose(devDqOe) |-> !reN || (cle && ale))
		else $error("output enabled without read request");
	AST_DQS_OUT: assert property (devDqsOe && $changed(devDqs) |-> $past(cle && ale))
		else $error("strobe toggled outside output phase");
	AST_ADL_WAIT: assert property (ale && !cle && $rose(weN) |-> ##1 weN [*8])
		else $error("data strobe too soon after address");
	AST_SYNC_DUP: assert property (hostDqsOe && $fell(hostDqs) |-> hostDq == dqRise_q)
		else $error("falling strobe byte differs from rising");
	AST_CMD_IDLE: assert property ($rose(cle) && !ale |-> rdy)
		else $error("command issued while busy");
	AST_NO_STATUS: assert property (cle && !ale && hostDqOe |->
		hostDq != CMD_READ_STATUS && hostDq != 8'h78)
		else $error("status command issued");
endmodule : nfc_link_chk
`default_nettype wire

// file: verification/tb_top.sv
/*
 * Self-checking bench: controller and feature store joined by the link,
 * driven through the controller's request port with random and fixed cases.
 * Assumes the controller polls the ready pin and handles one request at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import nfc_pkg::*;

	localparam int LIMIT = 40000;
	logic clk = 1'b0;
	logic rst_b;
	logic reqValid;
	nfc_op_e reqOp;
	logic [7:0] reqAddr;
	logic [7:0] reqParam;
	logic reqReady;
	logic rspValid;
	logic [31:0] rspData;
	logic linkSync;
	logic syncActive;
	logic [3:0] timingMode;
	logic [1:0] driveLevelA;
	logic [1:0] driveLevelB;
	int n_fail = 0;
	int samples_checked = 0;
	int busyCnt = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h00013415;
	logic [7:0] tmr = 8'h00;
	logic [1:0] drA = 2'h2;
	logic [1:0] drB = 2'h2;
	logic [7:0] addrList [3] = '{FA_TIMING, FA_DRIVE_A, FA_DRIVE_B};

	nfc_link_if link();
	nfc_host u_nfc_host (.clk, .rst_b, .link(link), .reqValid, .reqOp, .reqAddr, .reqParam,
		.reqReady, .rspValid, .rspData, .linkSync);
	nfc_device u_nfc_device (.clk, .rst_b, .link(link), .syncActive, .timingMode, .driveLevelA,
		.driveLevelB);
	nfc_link_chk u_nfc_link_chk (.clk(clk), .rst_b(rst_b), .cle(link.cle), .ale(link.ale),
		.weN(link.weN), .reN(link.reN), .hostDq(link.hostDq), .hostDqOe(link.hostDqOe),
		.hostDqs(link.hostDqs), .hostDqsOe(link.hostDqsOe), .devDqOe(link.devDqOe),
		.devDqs(link.devDqs), .devDqsOe(link.devDqsOe), .rdy(link.rdy));

	always #4 clk = ~clk;

	// Busy length restarts at the edge that takes a request
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (reqValid && reqReady) begin
			busyCnt <= 0;
		end else if (link.rdy === 1'b0) begin
			busyCnt <= busyCnt + 1;
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	function automatic logic [31:0] expGet(input logic [7:0] a);
		case (a)
			FA_TIMING: return {24'h0, tmr};
			FA_DRIVE_A: return {30'h0, drA};
			FA_DRIVE_B: return {30'h0, drB};
			default: return 32'h0;
		endcase
	endfunction : expGet

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// Drives at falling edges so the taking edge sees settled inputs
	task automatic runOp(input nfc_op_e op, input logic [7:0] a, input logic [7:0] p);
		@(negedge clk);
		while (reqReady !== 1'b1 && cycles < LIMIT) begin
			@(negedge clk);
		end
		reqOp = op;
		reqAddr = a;
		reqParam = p;
		reqValid = 1'b1;
		@(negedge clk);
		reqValid = 1'b0;
		while (rspValid !== 1'b1 && cycles < LIMIT) begin
			@(negedge clk);
		end
		// A hang is counted as a mismatch and ends the run
		if (cycles >= LIMIT) begin
			n_fail++;
			give_verdict();
		end
	endtask : runOp

	task automatic outChk();
		chk({23'h0, syncActive, timingMode, driveLevelA, driveLevelB},
			{23'h0, tmr[5:4] == IF_SYNC, tmr[3:0], drA, drB});
	endtask : outChk

	task automatic getChk(input logic [7:0] a);
		runOp(OP_GET, a, 8'h00);
		chk(rspData, expGet(a));
		chk(busyCnt, {22'h0, FEAT_CNT});
	endtask : getChk

	task automatic setF(input logic [7:0] a, input logic [7:0] p);
		logic [BUSY_W-1:0] e;
		e = (a == FA_TIMING && p[5:4] != tmr[5:4]) ? ITC_CNT : FEAT_CNT;
		runOp(OP_SET, a, p);
		chk(busyCnt, {22'h0, e});
		if (a == FA_TIMING) tmr = p;
		if (a == FA_DRIVE_A) drA = p[1:0];
		if (a == FA_DRIVE_B) drB = p[1:0];
		outChk();
	endtask : setF

	initial begin
		logic [7:0] a;
		logic [7:0] p;
		rst_b = 1'b0;
		reqValid = 1'b0;
		reqOp = OP_GET;
		reqAddr = 8'h00;
		reqParam = 8'h00;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 3; i++) getChk(addrList[i]);
		outChk();
		$display("test power-on values done");
		for (int i = 1; i < 3; i++) begin
			for (int v = 0; v < 4; v++) begin
				setF(addrList[i], 8'(v));
				getChk(addrList[i]);
			end
		end
		$display("test drive codes done");
		repeat (8) begin
			seed = xs(seed);
			a = (seed[1:0] == 2'h3) ? seed[15:8] : addrList[seed[1:0]];
			// Kept clear of mapped and omitted feature places
			if (seed[1:0] == 2'h3 && a inside {FA_TIMING, FA_DRIVE_A, FA_DRIVE_B, 8'h81, 8'h90}) a = 8'h42;
			p = (a == FA_TIMING) ? 8'(seed[18:16] % 3'h6) : seed[23:16] | 8'h01;
			if (a == FA_DRIVE_A || a == FA_DRIVE_B) p[7:2] = 6'h0;
			setF(a, p);
			getChk(a);
			getChk(FA_DRIVE_A);
		end
		$display("test random writes done");
		setF(FA_TIMING, 8'h05);
		runOp(OP_RESET, 8'h00, 8'h00);
		chk(busyCnt, {22'h0, RST_CNT});
		for (int i = 0; i < 3; i++) getChk(addrList[i]);
		$display("test reset in async done");
		setF(FA_TIMING, 8'h14);
		chk({31'h0, linkSync}, 32'h1);
		setF(FA_DRIVE_B, 8'h01);
		getChk(FA_DRIVE_B);
		getChk(FA_TIMING);
		runOp(OP_SYNC_RESET, 8'h00, 8'h00);
		chk(busyCnt, {22'h0, RST_CNT});
		getChk(FA_TIMING);
		runOp(OP_RESET, 8'h00, 8'h00);
		tmr = 8'h00;
		chk(busyCnt, {22'h0, RST_CNT});
		outChk();
		chk({31'h0, linkSync}, 32'h0);
		for (int i = 0; i < 3; i++) getChk(addrList[i]);
		$display("test sync interface done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
